// [core/flpc_top.sv]
// Control logic of a single-channel flash LED driver: pulse-count
// programming, flash sequencing, safety timer and latch-off faults.
// Assumes flash pins and comparator flags are synchronous to ref_clk; enProgPin is synchronised here.
//
// Behaviour
// - Flash starts on rising flash trigger.
// - Inhibit drops flash to default movie level.
// - Movie level is one of 16 log codes.
// - Flash overrides movie; no movie return afterwards.
// - Low sink after overvoltage for 1.4ms latches off.
// - Safety timer ends flash at programmed time.
// - Startup test current; short LED disables channel.
// - Over-temperature for 1.4ms while lit latches off.
// - Flash ends on trigger fall or timeout.
// - Movie register write changes active flash current.
// - Count edges; latch after 500us high.
// - Counts 17 to 20 select address 0 to 3.
// - Counts 1 to 16 are data writes.
// - Each register holds a 4-bit value.
// - Repeated data writes reuse latched address.
// - First edge after disable selects address 0.
// - 500us low shuts down, clearing everything.
// - Unwritten registers use their defaults.
// - Movie code 1 is 100%, 16 is 5.5%.
// - Timer code 1 off; 2-8 give 0.25-1.75s.
// - Output codes 1-2 off, 3-4 on.
// - Ratio codes 1-4 give 100/84/70/62%.
`timescale 1ns/1ps
module flpc_top #(
  parameter int LATCH_CYCLES       = flpc_pkg::LATCH_CYCLES,
  parameter int OFF_CYCLES         = flpc_pkg::OFF_CYCLES,
  parameter int FAULT_CYCLES       = flpc_pkg::FAULT_CYCLES,
  parameter int SAFETY_STEP_CYCLES = flpc_pkg::SAFETY_STEP_CYCLES
) (
  // Clock and reset
  input  wire logic       ref_clk,
  input  wire logic       reset,
  // Host pins
  input  wire logic       enProgPin,
  input  wire logic       flash_trigger_in,
  input  wire logic       flash_inhibit_in,
  // Analog comparator flags on led_sink_pin and die
  input  wire logic       sinkBelowFault,
  input  wire logic       outputAtOvp,
  input  wire logic       sinkAboveShort,
  input  wire logic       overTemp,
  // Power stage control
  output logic            deviceEnabled,
  output logic            boostEnable,
  output logic            sinkEnable,
  output logic            testCurrentOn,
  // Current selection
  output logic [1:0]      lightMode,
  output logic [3:0]      movieLevelCode,
  output logic [1:0]      flashRatioCode,
  // Status
  output logic            faultOpenLed,
  output logic            faultThermal,
  output logic            faultShortLed
);

  // ----------------------------------------------------------------
  // Parameter checks
  // ----------------------------------------------------------------
  if (SAFETY_STEP_CYCLES < 2) begin : g_chk
    $error("flpc_top SAFETY_STEP_CYCLES must be at least 2");
  end

  localparam int PW = $clog2(SAFETY_STEP_CYCLES);
  localparam logic [PW-1:0] STEP_LAST = PW'(SAFETY_STEP_CYCLES - 1);
  localparam logic [4:0] TEST_LAST = 5'(flpc_pkg::STARTUP_TEST_CYCLES - 1);

  // ----------------------------------------------------------------
  // Pin synchroniser and edges
  // ----------------------------------------------------------------
  logic enMeta;
  logic enLevel;
  logic enPrev;
  logic enRise;
  logic trigPrev;
  logic trigRise;

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      enMeta  <= 1'b0;
      enLevel <= 1'b0;
      enPrev  <= 1'b0;
    end else begin
      enMeta  <= enProgPin;
      enLevel <= enMeta;
      enPrev  <= enLevel;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      trigPrev <= 1'b0;
    end else begin
      trigPrev <= flash_trigger_in;
    end
  end

  assign enRise   = enLevel && !enPrev;
  assign trigRise = flash_trigger_in && !trigPrev;

  // ----------------------------------------------------------------
  // High and low duration timers
  // ----------------------------------------------------------------
  logic latchNow;
  logic shutdown;
  logic enabled;

  // latch timeout measured on high time
  flpc_run_timer #(.LIMIT(LATCH_CYCLES)) u_latch (
    .ref_clk (ref_clk),
    .reset   (reset),
    .run     (enLevel && enabled),
    .expired (latchNow)
  );

  // off timeout measured on low time
  flpc_run_timer #(.LIMIT(OFF_CYCLES)) u_off (
    .ref_clk (ref_clk),
    .reset   (reset),
    .run     (!enLevel && enabled),
    .expired (shutdown)
  );

  // first edge enables with address already zero
  always_ff @(posedge ref_clk) begin
    if (reset || shutdown) begin
      enabled <= 1'b0;
    end else if (enRise) begin
      enabled <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Edge counter and decode
  // ----------------------------------------------------------------
  logic [4:0] edgeCount;
  logic [1:0] address;
  logic       isData;
  logic       isAddr;
  logic       doWrite;

  always_ff @(posedge ref_clk) begin
    if (reset || shutdown || latchNow) begin
      edgeCount <= 5'h00;
    end else if (enRise && edgeCount != flpc_pkg::EDGE_SAT) begin
      edgeCount <= edgeCount + 5'h01;
    end
  end

  assign isData = (edgeCount >= flpc_pkg::EDGE_DATA_MIN)
               && (edgeCount <= flpc_pkg::EDGE_DATA_MAX);
  assign isAddr = (edgeCount >= flpc_pkg::EDGE_ADDR_FIRST)
               && (edgeCount <= flpc_pkg::EDGE_ADDR_LAST);
  assign doWrite = latchNow && isData;

  // address select; larger counts fall through
  // address stays until changed or shutdown
  always_ff @(posedge ref_clk) begin
    if (reset || shutdown) begin
      address <= flpc_pkg::REG_MOVIE_LEVEL;
    end else if (latchNow && isAddr) begin
      address <= 2'(edgeCount - flpc_pkg::EDGE_ADDR_FIRST);
    end
  end

  // ----------------------------------------------------------------
  // Data registers
  // ----------------------------------------------------------------
  logic [3:0] regCode [4];
  logic [3:0] regWritten;

  // data write to addressed register; 4-bit store
  always_ff @(posedge ref_clk) begin
    if (reset || shutdown) begin
      for (int i = 0; i < 4; i++) begin
        regCode[i] <= flpc_pkg::CODE_RESET;
      end
      regWritten <= 4'h0;
    end else if (doWrite) begin
      regCode[address]    <= 4'(edgeCount - flpc_pkg::EDGE_DATA_MIN);
      regWritten[address] <= 1'b1;
    end
  end

  logic [3:0] effMovie;
  logic [3:0] effSafety;
  logic [3:0] effOutput;
  logic [3:0] effRatio;

  assign effMovie  = regWritten[flpc_pkg::REG_MOVIE_LEVEL]
                   ? regCode[flpc_pkg::REG_MOVIE_LEVEL] : flpc_pkg::DEF_MOVIE_CODE;
  assign effSafety = regWritten[flpc_pkg::REG_SAFETY_TIME]
                   ? regCode[flpc_pkg::REG_SAFETY_TIME] : flpc_pkg::DEF_SAFETY_CODE;
  assign effOutput = regWritten[flpc_pkg::REG_OUTPUT_EN]
                   ? regCode[flpc_pkg::REG_OUTPUT_EN] : flpc_pkg::DEF_OUTPUT_CODE;
  assign effRatio  = regWritten[flpc_pkg::REG_FLASH_RATIO]
                   ? regCode[flpc_pkg::REG_FLASH_RATIO] : flpc_pkg::DEF_RATIO_CODE;

  logic       movieOn;
  logic [2:0] safetySteps;
  logic [1:0] ratioSel;

  assign movieOn = (effOutput >= flpc_pkg::MOVIE_ON_MIN);
  // timer steps of 0.25 s, code 0 disables
  assign safetySteps = (effSafety > flpc_pkg::SAFETY_MAX_CODE)
                     ? 3'(flpc_pkg::SAFETY_MAX_CODE) : 3'(effSafety);
  // ratio codes, higher data clamped to lowest ratio
  assign ratioSel = (effRatio > flpc_pkg::RATIO_MAX_CODE)
                  ? 2'(flpc_pkg::RATIO_MAX_CODE) : 2'(effRatio);

  // ----------------------------------------------------------------
  // Start-up short LED test
  // ----------------------------------------------------------------
  logic [4:0] testCount;
  logic       testing;
  logic       testDone;
  logic       shortTrip;

  always_ff @(posedge ref_clk) begin
    if (reset || shutdown) begin
      testCount <= 5'h00;
      testing   <= 1'b0;
      testDone  <= 1'b0;
    end else if (enRise && !enabled) begin
      testCount <= 5'h00;
      testing   <= 1'b1;
    end else if (testing) begin
      testCount <= testCount + 5'h01;
      if (testCount == TEST_LAST) begin
        testing  <= 1'b0;
        testDone <= 1'b1;
      end
    end
  end

  // sink still high at end of test disables channel
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      shortTrip <= 1'b0;
    end else if (testing && testCount == TEST_LAST && sinkAboveShort) begin
      shortTrip <= 1'b1;
    end else if (shutdown) begin
      shortTrip <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Protection latches
  // ----------------------------------------------------------------
  flpc_pkg::flpc_light_t lightState;
  flpc_pkg::flpc_light_t next_lightState;
  logic                  lit;
  logic                  openTrip;
  logic                  hotTrip;

  assign lit = (lightState == flpc_pkg::LIGHT_MOVIE)
            || (lightState == flpc_pkg::LIGHT_FLASH);

  flpc_fault_latch #(.DELAY(FAULT_CYCLES)) u_open (
    .ref_clk (ref_clk),
    .reset   (reset),
    .cond    (outputAtOvp && sinkBelowFault),
    .clear   (shutdown),
    .tripped (openTrip)
  );

  flpc_fault_latch #(.DELAY(FAULT_CYCLES)) u_hot (
    .ref_clk (ref_clk),
    .reset   (reset),
    .cond    (overTemp && lit),
    .clear   (shutdown),
    .tripped (hotTrip)
  );

  // ----------------------------------------------------------------
  // Flash safety timer
  // ----------------------------------------------------------------
  logic [PW-1:0] stepCount;
  logic [2:0]    stepsDone;
  logic          timedOut;

  always_ff @(posedge ref_clk) begin
    if (reset || lightState != flpc_pkg::LIGHT_FLASH) begin
      stepCount <= '0;
      stepsDone <= 3'h0;
    end else if (stepCount == STEP_LAST) begin
      stepCount <= '0;
      stepsDone <= stepsDone + 3'h1;
    end else begin
      stepCount <= stepCount + PW'(1);
    end
  end

  // code 0 keeps the timer from expiring
  assign timedOut = (safetySteps != 3'h0) && (stepsDone == safetySteps);

  // ----------------------------------------------------------------
  // Light sequencer
  // ----------------------------------------------------------------
  // flash on edge, spent until disable
  always_comb begin
    next_lightState = lightState;
    case (lightState)
      flpc_pkg::LIGHT_OFF: begin
        if (enabled && movieOn) next_lightState = flpc_pkg::LIGHT_MOVIE;
      end
      flpc_pkg::LIGHT_MOVIE: begin
        if (!enabled || !movieOn) next_lightState = flpc_pkg::LIGHT_OFF;
      end
      flpc_pkg::LIGHT_FLASH: begin
        if (!flash_trigger_in || timedOut) next_lightState = flpc_pkg::LIGHT_SPENT;
      end
      flpc_pkg::LIGHT_SPENT: begin
        if (!enabled) next_lightState = flpc_pkg::LIGHT_OFF;
      end
      default: begin
        next_lightState = flpc_pkg::LIGHT_OFF;
      end
    endcase
    if (trigRise) next_lightState = flpc_pkg::LIGHT_FLASH;
  end

  // a tripped open-LED or thermal fault holds the light off
  always_ff @(posedge ref_clk) begin
    if (reset || shutdown || openTrip || hotTrip) begin
      lightState <= flpc_pkg::LIGHT_OFF;
    end else begin
      lightState <= next_lightState;
    end
  end

  // ----------------------------------------------------------------
  // Registered outputs
  // ----------------------------------------------------------------
  logic inhibited;

  assign inhibited = (lightState == flpc_pkg::LIGHT_FLASH) && flash_inhibit_in;

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      deviceEnabled <= 1'b0;
      boostEnable   <= 1'b0;
      sinkEnable    <= 1'b0;
      testCurrentOn <= 1'b0;
    end else begin
      deviceEnabled <= enabled;
      boostEnable   <= lit && !shortTrip && !openTrip && !hotTrip;
      sinkEnable    <= lit && !shortTrip && !openTrip && !hotTrip;
      testCurrentOn <= testing;
    end
  end

  // inhibit shows the default movie level; level live in flash
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      lightMode      <= flpc_pkg::MODE_OFF;
      movieLevelCode <= flpc_pkg::CODE_RESET;
      flashRatioCode <= 2'h0;
    end else begin
      if (inhibited || lightState == flpc_pkg::LIGHT_MOVIE) begin
        lightMode <= flpc_pkg::MODE_MOVIE;
      end else if (lightState == flpc_pkg::LIGHT_FLASH) begin
        lightMode <= flpc_pkg::MODE_FLASH;
      end else begin
        lightMode <= flpc_pkg::MODE_OFF;
      end
      movieLevelCode <= inhibited ? flpc_pkg::DEF_MOVIE_CODE : effMovie;
      flashRatioCode <= ratioSel;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      faultOpenLed  <= 1'b0;
      faultThermal  <= 1'b0;
      faultShortLed <= 1'b0;
    end else begin
      faultOpenLed  <= openTrip;
      faultThermal  <= hotTrip;
      faultShortLed <= shortTrip;
    end
  end
endmodule

// [core/flpc_pkg.sv]
// Constants, codes and types for the flash LED pulse-count controller.
// Assumes a single 125 MHz clock.
package flpc_pkg;

  // ----------------------------------------------------------------
  // Timebase
  // ----------------------------------------------------------------
  localparam int CLK_MHZ          = 125;
  localparam int LATCH_TIMEOUT_US = 500;
  localparam int OFF_TIMEOUT_US   = 500;
  localparam int FAULT_DELAY_US   = 1400;
  localparam int SAFETY_STEP_MS   = 250;
  localparam int LATCH_CYCLES     = LATCH_TIMEOUT_US * CLK_MHZ;
  localparam int OFF_CYCLES       = OFF_TIMEOUT_US * CLK_MHZ;
  localparam int FAULT_CYCLES     = FAULT_DELAY_US * CLK_MHZ;
  localparam int SAFETY_STEP_CYCLES = SAFETY_STEP_MS * 1000 * CLK_MHZ;
  localparam int STARTUP_TEST_CYCLES = 16;

  // ----------------------------------------------------------------
  // Register addresses and edge counts
  // ----------------------------------------------------------------
  localparam logic [1:0] REG_MOVIE_LEVEL  = 2'h0;
  localparam logic [1:0] REG_SAFETY_TIME  = 2'h1;
  localparam logic [1:0] REG_OUTPUT_EN    = 2'h2;
  localparam logic [1:0] REG_FLASH_RATIO  = 2'h3;
  localparam logic [4:0] EDGE_DATA_MIN    = 5'h01;
  localparam logic [4:0] EDGE_DATA_MAX    = 5'h10;
  localparam logic [4:0] EDGE_ADDR_FIRST  = 5'h11;
  localparam logic [4:0] EDGE_ADDR_LAST   = 5'h14;
  localparam logic [4:0] EDGE_SAT         = 5'h1F;

  // ----------------------------------------------------------------
  // Stored codes are data value minus one
  // ----------------------------------------------------------------
  localparam logic [3:0] DEF_MOVIE_CODE   = 4'h0;
  localparam logic [3:0] DEF_SAFETY_CODE  = 4'h4;
  localparam logic [3:0] DEF_OUTPUT_CODE  = 4'h3;
  localparam logic [3:0] DEF_RATIO_CODE   = 4'h0;
  localparam logic [3:0] SAFETY_OFF_CODE  = 4'h0;
  localparam logic [3:0] SAFETY_MAX_CODE  = 4'h7;
  localparam logic [3:0] MOVIE_ON_MIN     = 4'h2;
  localparam logic [3:0] RATIO_MAX_CODE   = 4'h3;
  localparam logic [3:0] CODE_RESET       = 4'h0;

  // ----------------------------------------------------------------
  // Light output modes and sequencer states
  // ----------------------------------------------------------------
  localparam logic [1:0] MODE_OFF   = 2'h0;
  localparam logic [1:0] MODE_MOVIE = 2'h1;
  localparam logic [1:0] MODE_FLASH = 2'h2;

  typedef enum logic [1:0] {
    LIGHT_OFF   = 2'b00,
    LIGHT_MOVIE = 2'b01,
    LIGHT_FLASH = 2'b11,
    LIGHT_SPENT = 2'b10
  } flpc_light_t;

endpackage

// [core/flpc_run_timer.sv]
// Duration counter: counts while run is high, restarts when run drops.
// Assumes run is synchronous to clk.
`timescale 1ns/1ps
module flpc_run_timer #(
  parameter int LIMIT = 62500
) (
  // Clock and reset
  input  wire logic ref_clk,
  input  wire logic reset,
  // Control
  input  wire logic run,
  // One-cycle pulse when run has lasted LIMIT cycles
  output logic      expired
);
  localparam int W = $clog2(LIMIT + 1);
  localparam logic [W-1:0] LAST = W'(LIMIT - 1);

  if (LIMIT < 2) begin : g_chk
    $error("flpc_run_timer LIMIT must be at least 2");
  end

  logic [W-1:0] count;
  logic         done;

  always_ff @(posedge ref_clk) begin
    if (reset || !run) begin
      count <= '0;
      done  <= 1'b0;
    end else if (!done) begin
      count <= count + W'(1);
      done  <= (count == LAST);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset || !run) begin
      expired <= 1'b0;
    end else begin
      expired <= !done && (count == LAST);
    end
  end
endmodule

// [core/flpc_fault_latch.sv]
// Persistence filter with sticky trip for a protection condition.
// Assumes cond is synchronous to clk; clear comes from shutdown.
`timescale 1ns/1ps
module flpc_fault_latch #(
  parameter int DELAY = 175000
) (
  // Clock and reset
  input  wire logic ref_clk,
  input  wire logic reset,
  // Condition and release
  input  wire logic cond,
  input  wire logic clear,
  // Sticky trip level
  output logic      tripped
);
  localparam int W = $clog2(DELAY + 2);
  localparam logic [W-1:0] LAST = W'(DELAY);

  if (DELAY < 1) begin : g_chk
    $error("flpc_fault_latch DELAY must be at least 1");
  end

  logic [W-1:0] count;
  logic         hit;

  assign hit = cond && (count == LAST);

  always_ff @(posedge ref_clk) begin
    if (reset || !cond || clear) begin
      count <= '0;
    end else if (count != LAST) begin
      count <= count + W'(1);
    end
  end

  // Trip wins over clear
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      tripped <= 1'b0;
    end else begin
      tripped <= hit || (tripped && !clear);
    end
  end
endmodule

// [tb/flpc_top_sva.sv]
// Assertions on the pins of flpc_top.
// Assumes reset is synchronous and active high.
`timescale 1ns/1ps
module flpc_top_sva #(
  parameter int FAULT_CYCLES = 30,
  parameter int OFF_CYCLES   = 60
) (
  // Clock and pins
  input wire logic       ref_clk,
  input wire logic       reset,
  input wire logic       enProgPin,
  input wire logic       flash_trigger_in,
  input wire logic       flash_inhibit_in,
  input wire logic       overTemp,
  // Outputs
  input wire logic       deviceEnabled,
  input wire logic       boostEnable,
  input wire logic       sinkEnable,
  input wire logic [1:0] lightMode,
  input wire logic [3:0] movieLevelCode,
  input wire logic [1:0] flashRatioCode,
  input wire logic       faultOpenLed,
  input wire logic       faultThermal,
  input wire logic       faultShortLed
);
  // ----------------------------------------------------------------
  // Duration counters
  // ----------------------------------------------------------------
  int lowCnt;
  int hotCnt;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);
  always_ff @(posedge ref_clk) begin
    if (reset || enProgPin) lowCnt <= 0;
    else if (lowCnt < OFF_CYCLES + 8) lowCnt <= lowCnt + 1;
  end
  always_ff @(posedge ref_clk) begin
    if (reset || !overTemp) hotCnt <= 0;
    else if (hotCnt < FAULT_CYCLES + 8 && (hotCnt != 0 || lightMode != flpc_pkg::MODE_OFF))
      hotCnt <= hotCnt + 1;
  end
  property p_flash_start;
    $rose(flash_trigger_in) && deviceEnabled && !flash_inhibit_in && !faultThermal
      && !faultOpenLed |-> ##[1:8] lightMode == flpc_pkg::MODE_FLASH;
  endproperty
  a_flash_start: assert property (p_flash_start) else $error("flash did not start");
  property p_inhibit;
    $rose(flash_inhibit_in) && lightMode == flpc_pkg::MODE_FLASH
      |-> ##[1:8] lightMode == flpc_pkg::MODE_MOVIE;
  endproperty
  a_inhibit: assert property (p_inhibit) else $error("inhibit ignored");
  property p_flash_end;
    $fell(flash_trigger_in) |-> ##[1:8] lightMode != flpc_pkg::MODE_FLASH;
  endproperty
  a_flash_end: assert property (p_flash_end) else $error("flash kept on");
  property p_no_return;
    $fell(flash_trigger_in) && !flash_inhibit_in && lightMode == flpc_pkg::MODE_FLASH
      |-> ##1 (lightMode != flpc_pkg::MODE_MOVIE) [*8];
  endproperty
  a_no_return: assert property (p_no_return) else $error("movie resumed");
  property p_thermal;
    hotCnt == FAULT_CYCLES + 8 |-> faultThermal;
  endproperty
  a_thermal: assert property (p_thermal) else $error("no thermal trip");
  property p_fault_off;
    faultThermal || faultOpenLed |-> ##2 !boostEnable && lightMode == flpc_pkg::MODE_OFF;
  endproperty
  a_fault_off: assert property (p_fault_off) else $error("output on in fault");
  property p_short;
    faultShortLed |-> !sinkEnable;
  endproperty
  a_short: assert property (p_short) else $error("sink on with short");
  property p_sticky;
    $fell(faultThermal) || $fell(faultOpenLed) |-> ##[0:2] !deviceEnabled;
  endproperty
  a_sticky: assert property (p_sticky) else $error("fault cleared early");
  property p_off;
    lowCnt == OFF_CYCLES + 8 |-> !deviceEnabled && movieLevelCode == 4'h0
      && flashRatioCode == 2'h0;
  endproperty
  a_off: assert property (p_off) else $error("no shutdown");
endmodule
bind flpc_top flpc_top_sva #(.FAULT_CYCLES(FAULT_CYCLES), .OFF_CYCLES(OFF_CYCLES)) i_sva (
  .ref_clk(ref_clk), .reset(reset), .enProgPin(enProgPin),
  .flash_trigger_in(flash_trigger_in), .flash_inhibit_in(flash_inhibit_in),
  .overTemp(overTemp), .deviceEnabled(deviceEnabled), .boostEnable(boostEnable),
  .sinkEnable(sinkEnable), .lightMode(lightMode), .movieLevelCode(movieLevelCode),
  .flashRatioCode(flashRatioCode), .faultOpenLed(faultOpenLed),
  .faultThermal(faultThermal), .faultShortLed(faultShortLed));

// [tb/flpc_host_model.sv]
// Host GPIO model driving the program and flash pins.
// Assumes pins idle low, as their pull-downs leave them.
`timescale 1ns/1ps
module flpc_host_model (
  // Clock
  input wire logic ref_clk,
  // Pins
  output logic     enProgPin,
  output logic     flashTrig,
  output logic     flashInh
);
  // ----------------------------------------------------------------
  // Pin sequences
  // ----------------------------------------------------------------
  initial begin
    enProgPin = 1'b0;
    flashTrig = 1'b0;
    flashInh  = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task automatic burst(input int n, input int hold);
    for (int i = 0; i < n; i++) begin
      enProgPin = 1'b0;
      tick(3);
      enProgPin = 1'b1;
      tick(3);
    end
    tick(hold);
  endtask
  task automatic set_flash(input logic trig, input logic inh);
    flashTrig = trig;
    flashInh  = inh;
  endtask
  task automatic shut(input int n);
    enProgPin = 1'b0;
    tick(n);
  endtask
endmodule

// [tb/tb.sv]
// Self-checking bench for flpc_top with shortened counts.
// Assumes the host model drives the pins after each rising edge.
`timescale 1ns/1ps
module tb;
  // ----------------------------------------------------------------
  // Bench
  // ----------------------------------------------------------------
  localparam int LAT = 40;
  localparam int OFFC = 60;
  localparam int FLT = 30;
  localparam int STEP = 50;
  localparam int HOLD = LAT + 12;
  logic       ref_clk = 1'b0;
  logic       reset = 1'b1;
  logic       enProgPin, flashTrig, flashInh;
  logic       sinkBelowFault = 1'b0, outputAtOvp = 1'b0;
  logic       sinkAboveShort = 1'b0, overTemp = 1'b0;
  logic       deviceEnabled, boostEnable, sinkEnable, testCurrentOn;
  logic       faultOpenLed, faultThermal, faultShortLed;
  logic [1:0] lightMode, flashRatioCode;
  logic [3:0] movieLevelCode;
  int         miscompares = 0;
  int         cmp_count = 0;
  always #4 ref_clk = ~ref_clk;
  flpc_host_model i_flpc_host_model (.ref_clk(ref_clk), .enProgPin(enProgPin),
    .flashTrig(flashTrig), .flashInh(flashInh));
  flpc_top #(.LATCH_CYCLES(LAT), .OFF_CYCLES(OFFC), .FAULT_CYCLES(FLT),
    .SAFETY_STEP_CYCLES(STEP)) i_flpc_top (
    .ref_clk(ref_clk), .reset(reset), .enProgPin(enProgPin),
    .flash_trigger_in(flashTrig), .flash_inhibit_in(flashInh),
    .sinkBelowFault(sinkBelowFault), .outputAtOvp(outputAtOvp),
    .sinkAboveShort(sinkAboveShort), .overTemp(overTemp),
    .deviceEnabled(deviceEnabled), .boostEnable(boostEnable), .sinkEnable(sinkEnable),
    .testCurrentOn(testCurrentOn), .lightMode(lightMode),
    .movieLevelCode(movieLevelCode), .flashRatioCode(flashRatioCode),
    .faultOpenLed(faultOpenLed), .faultThermal(faultThermal),
    .faultShortLed(faultShortLed));
  task automatic check(input logic [3:0] seen, input logic [3:0] exp, input string msg);
    cmp_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED %0t %s: got %h want %h", $time, msg, seen, exp);
    end
  endtask
  task automatic wr(input int addr, input int data);
    if (addr >= 0) i_flpc_host_model.burst(17 + addr, HOLD);
    i_flpc_host_model.burst(data, HOLD);
  endtask
  task automatic t_flash;
    wr(-1, 1);
    check(deviceEnabled, 1, "enable");
    check(lightMode, flpc_pkg::MODE_MOVIE, "movie on");
    check(flashRatioCode, 0, "ratio default");
    i_flpc_host_model.set_flash(1'b1, 1'b0);
    i_flpc_host_model.tick(10);
    check(lightMode, flpc_pkg::MODE_FLASH, "flash");
    i_flpc_host_model.set_flash(1'b1, 1'b1);
    i_flpc_host_model.tick(10);
    check(lightMode, flpc_pkg::MODE_MOVIE, "inhibit");
    i_flpc_host_model.set_flash(1'b1, 1'b0);
    wr(-1, 9);
    check(movieLevelCode, 8, "level in flash");
    check(lightMode, flpc_pkg::MODE_FLASH, "restored");
    i_flpc_host_model.set_flash(1'b0, 1'b0);
    i_flpc_host_model.tick(10);
    check(lightMode, flpc_pkg::MODE_OFF, "flash end");
  endtask
  task automatic t_write;
    wr(-1, 5);
    check(movieLevelCode, 4, "level 5");
    wr(-1, 16);
    check(movieLevelCode, 4'hF, "level 16");
    wr(3, 4);
    check(flashRatioCode, 3, "ratio 4");
    i_flpc_host_model.burst(21, HOLD);
    wr(-1, 2);
    check(flashRatioCode, 1, "ratio after 21");
    wr(2, 1);
    check(lightMode, flpc_pkg::MODE_OFF, "movie off");
    wr(-1, 3);
    check(lightMode, flpc_pkg::MODE_MOVIE, "movie on");
  endtask
  task automatic t_safety;
    i_flpc_host_model.shut(OFFC + 10);
    check(deviceEnabled, 0, "shutdown");
    check(flashRatioCode, 0, "cleared");
    wr(-1, 5);
    check(movieLevelCode, 4, "address zero");
    wr(1, 2);
    i_flpc_host_model.set_flash(1'b1, 1'b0);
    i_flpc_host_model.tick(STEP + 20);
    check(lightMode, flpc_pkg::MODE_OFF, "timeout");
    i_flpc_host_model.set_flash(1'b0, 1'b0);
    i_flpc_host_model.shut(OFFC + 10);
  endtask
  task automatic t_faults;
    wr(-1, 1);
    overTemp = 1'b1;
    i_flpc_host_model.tick(FLT + 10);
    overTemp = 1'b0;
    i_flpc_host_model.tick(20);
    check(faultThermal, 1, "thermal");
    check(lightMode, flpc_pkg::MODE_OFF, "latched");
    i_flpc_host_model.shut(OFFC + 10);
    check(faultThermal, 0, "thermal cleared");
    wr(-1, 1);
    outputAtOvp = 1'b1;
    sinkBelowFault = 1'b1;
    i_flpc_host_model.tick(FLT + 10);
    check(faultOpenLed, 1, "open led");
    outputAtOvp = 1'b0;
    sinkBelowFault = 1'b0;
    i_flpc_host_model.shut(OFFC + 10);
    sinkAboveShort = 1'b1;
    wr(-1, 1);
    check(faultShortLed, 1, "short led");
    check(sinkEnable, 0, "sink off");
    sinkAboveShort = 1'b0;
  endtask
  task automatic print_verdict;
    $display("compares %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    #400000;
    miscompares++;
    print_verdict();
  end
  initial begin
    repeat (12) @(posedge ref_clk);
    #1;
    reset = 1'b0;
    i_flpc_host_model.tick(4);
    t_flash();
    i_flpc_host_model.shut(OFFC + 10);
    t_write();
    t_safety();
    t_faults();
    print_verdict();
  end
endmodule
